// >>> src/conv_serial.sv
// Converter control and serial readout top level
// Assumes link pins are asynchronous to mclk and resynchronised here
`timescale 1ns/100ps

module conv_serial
  import conv_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int unsigned TO_W           = 20
)(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Serial link pins
  input  wire logic        select_n,
  input  wire logic        sclk,
  input  wire logic        din,
  // Combined result and ready pin
  output logic             result_out_and_ready_o,
  output logic             result_out_and_ready_oe,
  output logic             result_out_and_ready_pu,
  // Modulator codes
  input  wire logic [11:0] adc_code,
  input  wire logic [11:0] temp_code,
  // Conversion status
  output logic             single_mode,
  output logic [2:0]       rate_select,
  output logic             sensor_select,
  output logic             converting
);
  import conv_pkg::*;

  // Link state phases
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } link_state_t;

  // Whole link state
  typedef struct packed {
    logic [1:0]      cs_s;      // Select synchroniser
    logic [1:0]      ck_s;      // Clock synchroniser
    logic [1:0]      di_s;      // Data synchroniser
    logic            ck_prev;   // Last synced clock
    link_state_t     st;
    logic [15:0]     setup;     // Setup register
    logic [15:0]     result;    // Buffered result
    logic            fresh;     // Unread result pending
    logic [31:0]     tx;        // Outgoing shift word
    logic [15:0]     rx;        // Incoming shift word
    logic [5:0]      bits;      // Falling edges this frame
    logic [TO_W-1:0] lowcnt;    // Clock-low timer
    logic            start;     // Single-shot start pulse
    logic            dout;
    logic            oe;
    logic            pu;
  } link_t;

  link_t l_q;
  link_t l_d;

  sample_t       sample;
  logic          busy;
  setup_fields_t fields;

  // Setup read-back view: start bit zero, bit 0 one
  function automatic logic [15:0] setup_view(input logic [15:0] r);
    logic [15:0] v;
    v = r;
    v[SS_BIT]     = 1'b0;
    v[UNUSED_BIT] = 1'b1;
    setup_view = v;
  endfunction : setup_view

  // Fields feeding the scheduler
  always_comb
  begin
    fields.single_mode   = l_q.setup[MODE_BIT];
    fields.rate_select   = l_q.setup[RATE_HI:RATE_LO];
    fields.sensor_select = l_q.setup[SENSOR_BIT];
    fields.pull_up       = l_q.setup[PULLUP_BIT];
  end

  // Conversion pacing engine
  conv_sched u_sched (
    .mclk         (mclk),
    .nrst         (nrst),
    .fields       (fields),
    .start_single (l_q.start),
    .adc_code     (adc_code),
    .temp_code    (temp_code),
    .sample       (sample),
    .busy         (busy)
  );

  // Link edge decode and frame handling
  always_comb
  begin
    logic cs_low;
    logic rise;
    logic fall;
    logic [15:0] word;
    cs_low = 1'b0;
    rise   = 1'b0;
    fall   = 1'b0;
    word   = 16'h0;
    l_d = l_q;

    // Two-stage synchronisers, second stage only is read
    l_d.cs_s = {l_q.cs_s[0], select_n};
    l_d.ck_s = {l_q.ck_s[0], sclk};
    l_d.di_s = {l_q.di_s[0], din};
    l_d.ck_prev = l_q.ck_s[1];
    cs_low = ~l_q.cs_s[1];
    rise   = l_q.ck_s[1] & ~l_q.ck_prev;
    fall   = ~l_q.ck_s[1] & l_q.ck_prev;
    l_d.start = 1'b0;

    // New result lands in buffer only outside a frame
    if (sample.valid && l_q.st == ST_IDLE)
    begin
      l_d.result = sample.data;
      l_d.fresh  = 1'b1;
    end

    // Clock-low timer while a frame is open
    if (l_q.st != ST_IDLE && !l_q.ck_s[1])
      l_d.lowcnt = l_q.lowcnt + TO_W'(1);
    else
      l_d.lowcnt = '0;

    unique case (l_q.st)
      ST_IDLE:
      begin
        if (cs_low && rise)
        begin
          // First rising edge: bit 15 on the pin
          l_d.st   = ST_SHIFT;
          l_d.tx   = {l_q.result[14:0], setup_view(l_q.setup), 1'b1};
          l_d.dout = l_q.result[15];
          // A result landing on this very edge stays flagged as fresh
          l_d.fresh = sample.valid;
          l_d.bits = '0;
        end
        else
        begin
          // Idle: pin shows ready (low means fresh)
          l_d.dout = ~l_q.fresh;
        end
      end
      ST_SHIFT:
      begin
        if (rise && l_q.bits != '0)
        begin
          l_d.dout = l_q.tx[31];
          l_d.tx   = {l_q.tx[30:0], 1'b1};
        end
        if (fall)
        begin
          l_d.rx   = {l_q.rx[14:0], l_q.di_s[1]};
          l_d.bits = l_q.bits + 6'h1;
          if (l_q.bits + 6'h1 == FRAME_SHORT)
          begin
            word = {l_q.rx[14:0], l_q.di_s[1]};
            if (word[QUAL_HI:QUAL_LO] == QUAL_VALID)
            begin
              l_d.setup = word;
              l_d.setup[SS_BIT] = 1'b0;
              l_d.setup[UNUSED_BIT] = 1'b1;
              // Start only honoured while powered down
              l_d.start = word[SS_BIT] & word[MODE_BIT] & ~busy;
            end
          end
          // Setup written only from the first word; second ignored
          if (l_q.bits + 6'h1 == FRAME_LONG)
            l_d.st = ST_DONE;
        end
      end
      ST_DONE:
      begin
        // Held-low select: rearm for next frame
        l_d.st   = ST_IDLE;
        l_d.dout = ~l_q.fresh;
      end
      default: l_d.st = ST_IDLE;
    endcase

    // Select high or clock-low timeout resets the link
    if (!cs_low || l_q.lowcnt >= TO_W'(TIMEOUT_CYCLES))
    begin
      l_d.st     = ST_IDLE;
      l_d.bits   = '0;
      l_d.lowcnt = '0;
      if (!cs_low)
        l_d.dout = 1'b1;
    end

    // Pin drive and pull-up
    l_d.oe = cs_low;
    l_d.pu = ~cs_low & l_q.setup[PULLUP_BIT];
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      l_q        <= '0;
      l_q.cs_s   <= 2'h3;
      l_q.setup  <= SETUP_RESET;
      l_q.dout   <= 1'b1;
      l_q.tx     <= 32'hffff_ffff;
    end
    else
    begin
      l_q <= l_d;
    end
  end

  // Status mirrors, also flip-flops
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      single_mode   <= SETUP_RESET[MODE_BIT];
      rate_select   <= SETUP_RESET[RATE_HI:RATE_LO];
      sensor_select <= SETUP_RESET[SENSOR_BIT];
      converting    <= 1'b0;
    end
    else
    begin
      single_mode   <= fields.single_mode;
      rate_select   <= fields.rate_select;
      sensor_select <= fields.sensor_select;
      converting    <= busy;
    end
  end

  assign result_out_and_ready_o  = l_q.dout;
  assign result_out_and_ready_oe = l_q.oe;
  assign result_out_and_ready_pu = l_q.pu;

endmodule : conv_serial

// >>> inc/conv_pkg.sv
// Shared constants and types for the converter serial setup and readout block
// Assumes a 10 MHz system clock and a serial link sampled in that domain
package conv_pkg;

  // Setup register field positions
  localparam int unsigned SS_BIT      = 15;
  localparam int unsigned MODE_BIT    = 8;
  localparam int unsigned RATE_HI     = 7;
  localparam int unsigned RATE_LO     = 5;
  localparam int unsigned SENSOR_BIT  = 4;
  localparam int unsigned PULLUP_BIT  = 3;
  localparam int unsigned QUAL_HI     = 2;
  localparam int unsigned QUAL_LO     = 1;
  localparam int unsigned UNUSED_BIT  = 0;

  // Setup reset value and valid write code
  localparam logic [15:0] SETUP_RESET = 16'h058b;
  localparam logic [1:0]  QUAL_VALID  = 2'h1;

  // Frame lengths in bits
  localparam logic [5:0]  FRAME_SHORT = 6'h10;
  localparam logic [5:0]  FRAME_LONG  = 6'h20;

  // Clock and timeout figures
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned TIMEOUT_MS   = 28;
  localparam int unsigned TIMEOUT_CYC  = CLK_HZ / 1000 * TIMEOUT_MS;

  // System clock cycles per conversion, per rate code
  localparam int unsigned CONV_CYC_128  = CLK_HZ / 128;
  localparam int unsigned CONV_CYC_250  = CLK_HZ / 250;
  localparam int unsigned CONV_CYC_490  = CLK_HZ / 490;
  localparam int unsigned CONV_CYC_920  = CLK_HZ / 920;
  localparam int unsigned CONV_CYC_1600 = CLK_HZ / 1600;
  localparam int unsigned CONV_CYC_2400 = CLK_HZ / 2400;
  localparam int unsigned CONV_CYC_3300 = CLK_HZ / 3300;

  // Decoded setup fields for the conversion engine
  typedef struct packed {
    logic       single_mode;
    logic [2:0] rate_select;
    logic       sensor_select;
    logic       pull_up;
  } setup_fields_t;

  // Converter sample path toward the buffer
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } sample_t;

endpackage : conv_pkg

// >>> src/conv_sched.sv
// Conversion scheduler: paces conversions by rate and mode
// Assumes setup fields and start pulse come from the same clock domain
`timescale 1ns/100ps

module conv_sched
  import conv_pkg::*;
#(
  parameter int unsigned CNT_W = 24
)(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          nrst,
  // Setup and control
  input  wire setup_fields_t fields,
  input  wire logic          start_single,
  // Analog result from the modulator
  input  wire logic [11:0]   adc_code,
  input  wire logic [11:0]   temp_code,
  // Completed sample
  output conv_pkg::sample_t  sample,
  output logic               busy
);
  import conv_pkg::*;

  // All scheduler state
  typedef struct packed {
    logic             busy;
    logic [CNT_W-1:0] cnt;
    sample_t          out;
  } sched_t;

  sched_t s_q;
  sched_t s_d;

  // Cycle count for a rate code
  function automatic logic [CNT_W-1:0] rate_cycles(input logic [2:0] code);
    unique case (code)
      3'h0:    rate_cycles = CNT_W'(CONV_CYC_128);
      3'h1:    rate_cycles = CNT_W'(CONV_CYC_250);
      3'h2:    rate_cycles = CNT_W'(CONV_CYC_490);
      3'h3:    rate_cycles = CNT_W'(CONV_CYC_920);
      3'h4:    rate_cycles = CNT_W'(CONV_CYC_1600);
      3'h5:    rate_cycles = CNT_W'(CONV_CYC_2400);
      default: rate_cycles = CNT_W'(CONV_CYC_3300);
    endcase
  endfunction : rate_cycles

  // Next state of the scheduler
  always_comb
  begin
    s_d = s_q;
    s_d.out.valid = 1'b0;
    if (s_q.busy)
    begin
      if (s_q.cnt <= CNT_W'(1))
      begin
        // Conversion done, present sample
        s_d.out.valid = 1'b1;
        s_d.out.data  = {fields.sensor_select ? temp_code : adc_code, 4'h0};
        // Continuous mode chains the next one
        s_d.busy = ~fields.single_mode;
        s_d.cnt  = rate_cycles(fields.rate_select);
      end
      else
      begin
        s_d.cnt = s_q.cnt - CNT_W'(1);
      end
    end
    else if (~fields.single_mode || start_single)
    begin
      s_d.busy = 1'b1;
      s_d.cnt  = rate_cycles(fields.rate_select);
    end
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sample = s_q.out;
  assign busy   = s_q.busy;

endmodule : conv_sched

// >>> tb/conv_serial_checker.sv
// Port checker for the converter serial block
// Assumes one mclk domain with synchronous active low reset
`timescale 1ns/100ps
module conv_serial_checker (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       nrst,
  // Link and pin
  input wire logic       select_n,
  input wire logic       result_out_and_ready_o,
  input wire logic       result_out_and_ready_oe,
  input wire logic       result_out_and_ready_pu,
  // Status mirrors
  input wire logic       single_mode,
  input wire logic [2:0] rate_select,
  input wire logic       sensor_select,
  input wire logic       converting
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Pin driven soon after select falls
  a_oe_on_select: assert property ($fell(select_n) |-> ##[1:4] result_out_and_ready_oe)
    else $error("pin not driven after select low");
  // Pin released while deselected
  a_oe_off_idle: assert property (select_n [*5] |-> !result_out_and_ready_oe)
    else $error("pin driven while deselected");
  // No pull-up while selected
  a_pu_off_sel: assert property (!select_n [*5] |-> !result_out_and_ready_pu)
    else $error("pull-up on while selected");
  // Setup cannot change without a frame
  a_setup_idle: assert property (select_n [*8] |=> $stable({single_mode, rate_select, sensor_select}))
    else $error("setup changed outside a frame");
  // Continuous mode restarts at once
  a_cont_restart: assert property (!single_mode && $fell(converting) |-> ##[1:3] converting)
    else $error("continuous conversion not restarted");
  // Single mode stays idle without a write
  a_single_idle: assert property (single_mode && !converting && select_n && $past(select_n, 8) |=> !converting)
    else $error("single mode started by itself");
  // Pin values held in reset
  a_reset_pin: assert property (disable iff (1'b0) !nrst |=> result_out_and_ready_o && !result_out_and_ready_oe
    && !converting)
    else $error("pin reset values wrong");
  // Setup mirrors at reset default
  a_reset_setup: assert property (disable iff (1'b0) !nrst |=> single_mode && rate_select == 3'h4
    && !sensor_select)
    else $error("setup reset values wrong");
endmodule : conv_serial_checker
bind conv_serial conv_serial_checker i_conv_serial_checker (.mclk, .nrst, .select_n, .result_out_and_ready_o,
  .result_out_and_ready_oe, .result_out_and_ready_pu, .single_mode, .rate_select, .sensor_select, .converting);

// >>> tb/spi_master_model.sv
// Serial master model: mode 1 frames, MSB first
// Assumes the bench resolves the shared pin level
`timescale 1ns/100ps
module spi_master_model (
  // Launch alignment clock
  input  wire logic mclk,
  // Link lines
  output logic      select_n,
  output logic      sclk,
  output logic      din,
  // Resolved pin level
  input  wire logic pin
);
  initial
  begin
    select_n = 1'b1;
    sclk     = 1'b0;
    din      = 1'b0;
  end
  // Frame of n bits; keep leaves select low afterwards
  task automatic xfer(input int n, input logic [31:0] tx, input bit keep, output logic [31:0] rx);
    rx = 32'h0;
    @(posedge mclk);
    #7;
    select_n = 1'b0;
    #800;
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'b1;
      din  = tx[n - 1 - i];
      #400;
      sclk = 1'b0;
      #400;
      rx = {rx[30:0], pin};
    end
    // Hold time over: show no stale level
    din = ~din;
    if (!keep)
      select_n = 1'b1;
    #800;
  endtask : xfer
endmodule : spi_master_model

// >>> tb/tb_top.sv
// Bench for the converter serial block through the master model
// Assumes 10 MHz mclk and a shortened link timeout
`timescale 1ns/100ps
module tb_top;
  import conv_pkg::*;
  logic        mclk;
  logic        nrst;
  logic        select_n, sclk, din;   // Link lines
  logic        pin_o, pin_oe, pin_pu; // Pin drive
  logic        pin;                   // Resolved pin level
  logic [11:0] adc_code, temp_code;   // Modulator codes
  logic        single_mode, sensor_select, converting;
  logic [2:0]  rate_select;
  logic [31:0] rx;                    // Received frame
  logic [15:0] w;                     // Setup word
  int          error_cnt = 0;
  int          checked = 0;
  int          cycles = 0;
  // Undriven pin: pull-up or changing level
  assign pin = pin_oe ? pin_o : (pin_pu | ~pin_o);
  conv_serial #(.TIMEOUT_CYCLES(200)) i_conv_serial (.mclk(mclk), .nrst(nrst), .select_n(select_n),
    .sclk(sclk), .din(din), .result_out_and_ready_o(pin_o), .result_out_and_ready_oe(pin_oe),
    .result_out_and_ready_pu(pin_pu), .adc_code(adc_code), .temp_code(temp_code),
    .single_mode(single_mode), .rate_select(rate_select), .sensor_select(sensor_select),
    .converting(converting));
  spi_master_model m (.mclk(mclk), .select_n(select_n), .sclk(sclk), .din(din), .pin(pin));
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  // Hang guard
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      error_cnt++;
      $display("ERROR %0t run too long", $time);
      end_of_test();
    end
  end
  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Wait n cycles, then step off the edge
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #7;
  endtask : wait_cyc
  // Counts and verdict
  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    nrst = 1'b0;
    adc_code = 12'h5a3;
    temp_code = 12'h3c1;
    wait_cyc(10);
    nrst = 1'b1;
    wait_cyc(3);
    // Bad qualifier codes leave setup alone
    for (int q = 0; q < 4; q++)
    begin
      if (q != 1)
      begin
        w = 16'h04c9 | {13'h0, q[1:0], 1'b0};
        m.xfer(32, {w, w}, 0, rx);
        chk(rx, {16'h0000, SETUP_RESET});
      end
    end
    chk({single_mode, rate_select, sensor_select}, 5'h18);
    $display("test qualifier done");
    // Continuous mode, second half differs
    m.xfer(32, {16'h04cb, 16'hffff}, 0, rx);
    chk({single_mode, rate_select}, 4'h6);
    wait_cyc(6100);
    m.xfer(16, 32'h0, 0, rx);
    chk(rx, 32'h00005a30);
    m.xfer(32, {16'h04db, 16'h04db}, 0, rx);
    chk(rx[15:0], 16'h04cb);
    wait_cyc(6100);
    m.xfer(16, 32'h0, 0, rx);
    chk(rx, 32'h00003c10);
    $display("test continuous done");
    // Select held low across conversions
    m.xfer(16, 32'h0, 1, rx);
    wait_cyc(6100);
    chk(pin, 1'b0);
    m.xfer(32, {16'h05cb, 16'h0000}, 0, rx);
    chk(rx, {16'h3c10, 16'h04db});
    $display("test select low done");
    // Single shot started by the start bit
    wait_cyc(6100);
    chk(converting, 1'b0);
    adc_code = 12'h123;
    m.xfer(32, {16'h85cb, 16'h85cb}, 0, rx);
    chk(rx[15:0], 16'h05cb);
    wait_cyc(3300);
    m.xfer(32, 32'h0, 0, rx);
    chk(rx, {16'h1230, 16'h05cb});
    chk(pin_pu, 1'b1);
    $display("test single shot done");
    // Aborted frames restart at bit 15
    m.xfer(5, 32'h0, 0, rx);
    m.xfer(16, 32'h0, 0, rx);
    chk(rx, 32'h00001230);
    m.xfer(3, 32'h0, 1, rx);
    wait_cyc(300);
    m.xfer(16, 32'h0, 0, rx);
    chk(rx, 32'h00001230);
    $display("test abort done");
    end_of_test();
  end
endmodule : tb_top
